// ==== rpm_actuator.sv ====
`timescale 1ns/1ps
module rpm_actuator (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        relayOn,
   output logic      [15:0] pulseCnt,
   output logic      [15:0] onLen,
   output logic      [15:0] offLen
);
   // ---------------------------------------------
   // Coil timing
   // ---------------------------------------------
   logic        prevOn_q;
   logic [15:0] run_q;
   // pulse and interval
   // Each phase length is latched when the coil changes state, so a valve
   // or pump sees whole pulses only; partial first phases are overwritten.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         prevOn_q <= 1'b0;
         run_q    <= 16'h0;
         pulseCnt <= 16'h0;
         onLen    <= 16'h0;
         offLen   <= 16'h0;
      end else begin
         prevOn_q <= relayOn;
         if (relayOn != prevOn_q) begin
            run_q <= 16'h1;
            if (prevOn_q) onLen <= run_q;
            else offLen <= run_q;
            if (relayOn) pulseCnt <= pulseCnt + 16'h1;
         end else begin
            run_q <= run_q + 16'h1;
         end
      end
   end
endmodule

// ==== rpm_modulator.sv ====
// Added by the designer: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
module rpm_modulator
   import rpm_pkg::*;
#(
   parameter int         TICK_DIV    = rpm_pkg::TICK_CYCLES,
   parameter logic       ALARM_RELAY = 1'b0
) (
   input  wire logic                     ref_clk,
   input  wire logic                     rst_n,
   input  wire logic [7:0]               wbAdr,
   input  wire logic [31:0]              wbDatI,
   output logic      [31:0]              wbDatO,
   input  wire logic [3:0]               wbSel,
   input  wire logic                     wbWe,
   input  wire logic                     wbCyc,
   input  wire logic                     wbStb,
   output logic                          wbAck,
   input  wire logic [9:0]               yInc,
   input  wire logic [9:0]               yDec,
   input  wire logic                     holdActive,
   input  wire logic [rpm_pkg::MSG_N-1:0] msgActive,
   input  wire logic [rpm_pkg::MSG_N-1:0] msgRelayMap,
   output logic                          relayOn
);
   import rpm_pkg::*;

   logic             tick;
   rpm_func_e        func_q;
   logic             pfm_q;
   rpm_act_e         act_q;
   rpm_hold_e        hold_q;
   rpm_dmode_e       dmode_q;
   logic [TW-1:0]    cycle_q;
   logic [TW-1:0]    minOn_q;
   logic [7:0]       freq_q;
   logic [8:0]       pulseLen_q;
   logic [9:0]       holdVal_q;
   logic [31:0]      class_q;
   logic             ack_q;
   logic [31:0]      datO_q;
   logic [9:0]       yLive;
   logic [9:0]       yEff_q;
   logic [TW-1:0]    pwmCnt_q;
   logic [TW-1:0]    onLen_q;
   logic [TW-1:0]    onCalc;
   rpm_phase_e       phase_q;
   logic [GW-1:0]    phCnt_q;
   logic [GW-1:0]    gapCalc;
   logic             diagErr;
   logic [MSG_N-1:0] classHit;
   logic             relayOn_q;
   logic             req;
   logic             wr;
   logic [31:0]      ctrlRd;
   logic [31:0]      wv;

   // ---------------------------------------------------------------
   // Time base
   // ---------------------------------------------------------------
   // tenth-second tick
   rpm_tick #(.DIV(TICK_DIV)) u_tick (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .tick    (tick)
   );

   // ---------------------------------------------------------------
   // Wishbone slave
   // ---------------------------------------------------------------
   // Byte lanes merge into the old value so partial writes keep other bytes.
   function automatic logic [31:0] merge(input logic [31:0] oldV,
                                         input logic [31:0] newV,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = oldV;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = newV[8*i +: 8];
         end
      end
      return r;
   endfunction

   assign req = wbCyc & wbStb & ~ack_q;
   assign wr  = req & wbWe;

   // The control word as software sees it.
   always_comb begin
      ctrlRd = '0;
      ctrlRd[CTRL_FUNC_LSB +: 2]  = func_q;
      ctrlRd[CTRL_MODE_BIT]       = pfm_q;
      ctrlRd[CTRL_ACT_LSB +: 2]   = act_q;
      ctrlRd[CTRL_HOLD_LSB +: 2]  = hold_q;
      ctrlRd[CTRL_DMODE_LSB +: 3] = dmode_q;
   end

   // Every request is answered one cycle later, so the ack drops after one cycle.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req;
      end
   end

   // Read data is captured with the request; unmapped addresses read zero.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         datO_q <= '0;
      end else if (req && !wbWe) begin
         unique case (wbAdr)
            ADDR_CTRL:   datO_q <= ctrlRd;
            ADDR_CYCLE:  datO_q <= 32'(cycle_q);
            ADDR_MINON:  datO_q <= 32'(minOn_q);
            ADDR_FREQ:   datO_q <= 32'(freq_q);
            ADDR_HOLDV:  datO_q <= 32'(holdVal_q);
            ADDR_CLASS:  datO_q <= class_q;
            ADDR_MAPPED: datO_q <= 32'(msgRelayMap);
            ADDR_STATUS: datO_q <= {6'h00, yEff_q, 12'h000, phase_q, diagErr, relayOn_q};
            default:     datO_q <= '0;
         endcase
      end
   end

   assign wbAck  = ack_q;
   assign wbDatO = datO_q;

   // ---------------------------------------------------------------
   // Configuration
   // ---------------------------------------------------------------
   assign wv = merge(ctrlRd, wbDatI, wbSel);

   // Illegal field codes are ignored so the enums never hold a bad value.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         act_q   <= ACT_NONE;
         pfm_q   <= 1'b0;
         hold_q  <= HOLD_IGNORE;
         func_q  <= ALARM_RELAY ? FUNC_DIAG : FUNC_OFF;
         dmode_q <= ALARM_RELAY ? DM_FAIL : DM_MAPPED;
      end else if (wr && wbAdr == ADDR_CTRL) begin
         pfm_q <= wv[CTRL_MODE_BIT];
         if (wv[CTRL_FUNC_LSB +: 2] <= 2'(FUNC_DIAG)) begin
            func_q <= rpm_func_e'(wv[CTRL_FUNC_LSB +: 2]);
         end
         if (wv[CTRL_ACT_LSB +: 2] <= 2'(ACT_DEC)) begin
            act_q <= rpm_act_e'(wv[CTRL_ACT_LSB +: 2]);
         end
         if (wv[CTRL_HOLD_LSB +: 2] <= 2'(HOLD_FIXED)) begin
            hold_q <= rpm_hold_e'(wv[CTRL_HOLD_LSB +: 2]);
         end
         if (wv[CTRL_DMODE_LSB +: 3] <= 3'(DM_FAIL)) begin
            dmode_q <= rpm_dmode_e'(wv[CTRL_DMODE_LSB +: 3]);
         end
      end
   end

   // Cycle duration and minimum on-time clamp against each other on write.
   always_ff @(posedge ref_clk) begin
      logic [31:0] v;
      v = '0;
      if (!rst_n) begin
         cycle_q <= TW'(CYCLE_RST_TICKS);
         minOn_q <= TW'(MINON_MIN_TICKS);
      end else if (wr && wbAdr == ADDR_CYCLE) begin
         v = merge(32'(cycle_q), wbDatI, wbSel);
         if (v < 32'(minOn_q)) begin
            cycle_q <= minOn_q;
         end else if (v > 32'(CYCLE_MAX_TICKS)) begin
            cycle_q <= TW'(CYCLE_MAX_TICKS);
         end else begin
            cycle_q <= v[TW-1:0];
         end
      end else if (wr && wbAdr == ADDR_MINON) begin
         v = merge(32'(minOn_q), wbDatI, wbSel);
         if (v < 32'(MINON_MIN_TICKS)) begin
            minOn_q <= TW'(MINON_MIN_TICKS);
         end else if (v > 32'(cycle_q)) begin
            minOn_q <= cycle_q;
         end else begin
            minOn_q <= v[TW-1:0];
         end
      end
   end

   // Pulse length is fixed here so the divider runs only on a write.
   always_ff @(posedge ref_clk) begin
      logic [31:0] v;
      v = '0;
      if (!rst_n) begin
         freq_q     <= 8'(FREQ_RST);
         pulseLen_q <= 9'(HALF_MIN_TICKS / FREQ_RST);
      end else if (wr && wbAdr == ADDR_FREQ) begin
         v = merge(32'(freq_q), wbDatI, wbSel);
         if (v < 32'(FREQ_MIN)) begin
            v = 32'(FREQ_MIN);
         end else if (v > 32'(FREQ_MAX)) begin
            v = 32'(FREQ_MAX);
         end
         freq_q     <= v[7:0];
         pulseLen_q <= 9'(32'(HALF_MIN_TICKS) / v);
      end
   end

   // Fixed hold value and per-message class codes.
   always_ff @(posedge ref_clk) begin
      logic [31:0] v;
      v = '0;
      if (!rst_n) begin
         holdVal_q <= '0;
         class_q   <= '0;
      end else if (wr && wbAdr == ADDR_HOLDV) begin
         v = merge(32'(holdVal_q), wbDatI, wbSel);
         holdVal_q <= (v > 32'(Y_FULL)) ? 10'(Y_FULL) : v[9:0];
      end else if (wr && wbAdr == ADDR_CLASS) begin
         class_q <= merge(class_q, wbDatI, wbSel);
      end
   end

   // ---------------------------------------------------------------
   // Manipulated variable
   // ---------------------------------------------------------------
   // part selection
   always_comb begin
      unique case (act_q)
         ACT_INC: yLive = yInc;
         ACT_DEC: yLive = yDec;
         default: yLive = '0;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         yEff_q <= '0;
      end else if (holdActive && hold_q == HOLD_FIXED) begin
         yEff_q <= holdVal_q;
      end else if (!(holdActive && hold_q == HOLD_FREEZE)) begin
         yEff_q <= (yLive > 10'(Y_FULL)) ? 10'(Y_FULL) : yLive;
      end
   end

   // ---------------------------------------------------------------
   // Width modulation
   // ---------------------------------------------------------------
   // On-share of the period; a share below the minimum is dropped.
   always_comb begin
      logic [23:0] p;
      p = 24'(yEff_q) * 24'(cycle_q);
      onCalc = TW'(p / 24'(Y_FULL));
      if (onCalc < minOn_q) begin
         onCalc = '0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n || func_q != FUNC_CTRL || pfm_q) begin
         pwmCnt_q <= '0;
         onLen_q  <= '0;
      end else if (tick) begin
         if (pwmCnt_q + 1'b1 >= cycle_q) begin
            pwmCnt_q <= '0;
            onLen_q  <= onCalc;
         end else begin
            pwmCnt_q <= pwmCnt_q + 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Frequency modulation
   // ---------------------------------------------------------------
   // Gap so that pulse plus gap spans 2*len*full/y; at full y it equals len.
   always_comb begin
      logic [GW-1:0] num;
      num = GW'(pulseLen_q) * GW'(2 * Y_FULL);
      if (yEff_q == '0) begin
         gapCalc = '0;
      end else begin
         gapCalc = num / GW'(yEff_q) - GW'(pulseLen_q);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n || func_q != FUNC_CTRL || !pfm_q) begin
         phase_q <= PH_IDLE;
         phCnt_q <= '0;
      end else if (tick) begin
         unique case (phase_q)
            PH_PULSE: begin
               if (phCnt_q <= GW'(1)) begin
                  phase_q <= PH_GAP;
                  phCnt_q <= gapCalc;
               end else begin
                  phCnt_q <= phCnt_q - 1'b1;
               end
            end
            PH_IDLE, PH_GAP: begin
               if (phCnt_q <= GW'(1) && yEff_q != '0) begin
                  phase_q <= PH_PULSE;
                  phCnt_q <= GW'(pulseLen_q);
               end else if (phCnt_q != '0) begin
                  phCnt_q <= phCnt_q - 1'b1;
               end
            end
            default: begin
               phase_q <= PH_IDLE;
               phCnt_q <= '0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Diagnostics
   // ---------------------------------------------------------------
   // class match
   for (genvar i = 0; i < MSG_N; i++) begin : g_class
      assign classHit[i] = msgActive[i]
                           && ({1'b0, class_q[2*i +: 2]} == 3'(dmode_q - 3'h1));
   end

   always_comb begin
      if (dmode_q == DM_MAPPED) begin
         diagErr = |(msgActive & msgRelayMap);
      end else begin
         diagErr = |classHit;
      end
   end

   // ---------------------------------------------------------------
   // Relay drive
   // ---------------------------------------------------------------
   // A width pulse of zero length never energizes, even at period start.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         relayOn_q <= 1'b0;
      end else begin
         unique case (func_q)
            FUNC_CTRL: relayOn_q <= pfm_q ? (phase_q == PH_PULSE) : (pwmCnt_q < onLen_q);
            FUNC_DIAG: relayOn_q <= ~diagErr;
            default:   relayOn_q <= 1'b0;
         endcase
      end
   end

   assign relayOn = relayOn_q;
endmodule

// ==== rpm_modulator_props.sv ====
`timescale 1ns/1ps
module rpm_modulator_props
   import rpm_pkg::*;
#(
   parameter int TICK_DIV = 4
) (
   input wire logic                        ref_clk,
   input wire logic                        rst_n,
   input wire logic [7:0]                  wbAdr,
   input wire logic [31:0]                 wbDatI,
   input wire logic [31:0]                 wbDatO,
   input wire logic [3:0]                  wbSel,
   input wire logic                        wbWe,
   input wire logic                        wbCyc,
   input wire logic                        wbStb,
   input wire logic                        wbAck,
   input wire logic [9:0]                  yInc,
   input wire logic [9:0]                  yDec,
   input wire logic                        holdActive,
   input wire logic [rpm_pkg::MSG_N-1:0]   msgActive,
   input wire logic [rpm_pkg::MSG_N-1:0]   msgRelayMap,
   input wire logic                        relayOn
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // ---------------------------------------------
   // Bus handshake
   // ---------------------------------------------
   // A request counts only while no answer is standing.
   logic req;
   logic rd;
   assign req = wbCyc && wbStb && !wbAck;
   assign rd  = req && !wbWe;
   chk_ack_follows: assert property (req |=> wbAck) else $error("ack missing after request");
   chk_ack_single: assert property (wbAck |=> !wbAck) else $error("ack longer than one cycle");
   chk_ack_idle: assert property (!(wbCyc && wbStb) |=> !wbAck) else $error("ack without request");
   chk_rdata_hold: assert property (!rd |=> $stable(wbDatO)) else $error("read data moved");
   // ---------------------------------------------
   // Read-back contents
   // ---------------------------------------------
   chk_unmapped_zero: assert property (rd && wbAdr > ADDR_STATUS |=> wbDatO == 32'h0)
      else $error("unmapped read not zero");
   chk_map_readonly: assert property (
      rd && wbAdr == ADDR_MAPPED |=> wbDatO == {16'h0, $past(msgRelayMap)})
      else $error("mapped list read wrong");
   chk_status_relay: assert property (
      rd && wbAdr == ADDR_STATUS |=> wbDatO[0] == $past(relayOn))
      else $error("status relay bit wrong");
   chk_status_pad: assert property (
      rd && wbAdr == ADDR_STATUS |=> wbDatO[31:26] == 6'h0 && wbDatO[15:4] == 12'h0)
      else $error("status spare bits set");
   cover property (req && wbWe);
   cover property (rd);
   cover property ($rose(relayOn));
   cover property ($fell(relayOn));
endmodule
bind rpm_modulator rpm_modulator_props #(.TICK_DIV(TICK_DIV)) u_props (
   .ref_clk(ref_clk), .rst_n(rst_n), .wbAdr(wbAdr), .wbDatI(wbDatI), .wbDatO(wbDatO),
   .wbSel(wbSel), .wbWe(wbWe), .wbCyc(wbCyc), .wbStb(wbStb), .wbAck(wbAck),
   .yInc(yInc), .yDec(yDec), .holdActive(holdActive), .msgActive(msgActive),
   .msgRelayMap(msgRelayMap), .relayOn(relayOn));

// ==== rpm_modulator_tb.sv ====
`timescale 1ns/1ps
module rpm_modulator_tb;
   import rpm_pkg::*;
   localparam int TD = 4;
   logic ref_clk, rst_n, wbWe, wbCyc, wbStb, wbAck, holdActive, relayOn, alarmOn;
   logic [7:0]  wbAdr;
   logic [31:0] wbDatI, wbDatO, rdv, alarmDat;
   logic [3:0]  wbSel;
   logic [9:0]  yInc, yDec;
   logic [15:0] msgActive, msgRelayMap, pulseCnt, onLen, offLen;
   int failures, checkCount, cycles;
   rpm_modulator #(.TICK_DIV(TD), .ALARM_RELAY(1'b0)) u_dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .wbAdr(wbAdr), .wbDatI(wbDatI), .wbDatO(wbDatO),
      .wbSel(wbSel), .wbWe(wbWe), .wbCyc(wbCyc), .wbStb(wbStb), .wbAck(wbAck),
      .yInc(yInc), .yDec(yDec), .holdActive(holdActive), .msgActive(msgActive),
      .msgRelayMap(msgRelayMap), .relayOn(relayOn));
   // A second copy strapped as the alarm relay shares the bus; only its resets differ.
   rpm_modulator #(.TICK_DIV(TD), .ALARM_RELAY(1'b1)) u_alarm (
      .ref_clk(ref_clk), .rst_n(rst_n), .wbAdr(wbAdr), .wbDatI(wbDatI), .wbDatO(alarmDat),
      .wbSel(wbSel), .wbWe(wbWe), .wbCyc(wbCyc), .wbStb(wbStb), .wbAck(),
      .yInc(yInc), .yDec(yDec), .holdActive(holdActive), .msgActive(msgActive),
      .msgRelayMap(msgRelayMap), .relayOn(alarmOn));
   rpm_actuator u_act (.ref_clk(ref_clk), .rst_n(rst_n), .relayOn(relayOn),
      .pulseCnt(pulseCnt), .onLen(onLen), .offLen(offLen));
   // ---------------------------------------------
   // Clock, report and watchdog
   // ---------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", checkCount, failures);
      if (failures == 0 && checkCount > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // The ceiling is several times the expected run, so only a real hang trips it.
   initial begin
      cycles = 0;
      forever begin
         @(posedge ref_clk);
         cycles++;
         if (cycles >= 20000) begin
            failures++;
            $display("ERROR %0t: run timed out", $time);
            complete_run();
         end
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checkCount++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // ---------------------------------------------
   // Bus access
   // ---------------------------------------------
   // The request stands until ack is seen at a rising edge; data is taken there.
   task automatic wbAccess(input logic [7:0] a, input logic we, input logic [31:0] d);
      @(posedge ref_clk);
      wbCyc  <= 1'b1;
      wbStb  <= 1'b1;
      wbWe   <= we;
      wbAdr  <= a;
      wbDatI <= d;
      wbSel  <= 4'hf;
      do begin
         @(posedge ref_clk);
      end while (wbAck !== 1'b1);
      rdv = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe  <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wbAccess(a, 1'b1, d);
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
      wbAccess(a, 1'b0, 32'h0);
      chk(rdv, exp);
   endtask
   // Phase lengths are in clock cycles: ticks times the divider.
   task automatic lens(input int onT, input int offT);
      repeat (300) @(posedge ref_clk);
      chk({16'h0, onLen}, onT * TD);
      chk({16'h0, offLen}, offT * TD);
   endtask
   task automatic quiet();
      logic [15:0] c;
      repeat (60) @(posedge ref_clk);
      c = pulseCnt;
      repeat (150) @(posedge ref_clk);
      chk({16'h0, pulseCnt}, {16'h0, c});
      chk({31'h0, relayOn}, 32'h0);
   endtask
   task automatic relayIs(input logic [15:0] act, input logic exp);
      @(posedge ref_clk);
      msgActive <= act;
      repeat (4) @(posedge ref_clk);
      chk({31'h0, relayOn}, {31'h0, exp});
   endtask
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   initial begin
      rst_n = 1'b0; wbAdr = 8'h0; wbDatI = 32'h0; wbSel = 4'h0; wbWe = 1'b0;
      wbCyc = 1'b0; wbStb = 1'b0; yInc = 10'd500; yDec = 10'd0; holdActive = 1'b0;
      msgActive = 16'h0; msgRelayMap = 16'h0000; failures = 0; checkCount = 0;
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      rdChk(ADDR_CTRL, 32'h0);
      chk(alarmDat, 32'h00000402);
      chk({31'h0, alarmOn}, 32'h1);
      rdChk(ADDR_CYCLE, 32'd100);
      rdChk(ADDR_MINON, 32'd3);
      rdChk(ADDR_FREQ, 32'd60);
      wr(ADDR_CYCLE, 32'd20000);
      rdChk(ADDR_CYCLE, 32'd9990);
      wr(ADDR_MINON, 32'd1);
      rdChk(ADDR_MINON, 32'd3);
      wr(ADDR_MINON, 32'd20000);
      rdChk(ADDR_MINON, 32'd9990);
      wr(ADDR_CYCLE, 32'd2);
      rdChk(ADDR_CYCLE, 32'd9990);
      wr(ADDR_MINON, 32'd3);
      wr(ADDR_CYCLE, 32'd10);
      wr(ADDR_FREQ, 32'd200);
      rdChk(ADDR_FREQ, 32'd180);
      wr(ADDR_FREQ, 32'd0);
      rdChk(ADDR_FREQ, 32'd1);
      wr(ADDR_FREQ, 32'd60);
      wr(ADDR_MAPPED, 32'hffffffff);
      rdChk(ADDR_MAPPED, 32'h00000000);
      wr(8'h40, 32'h12345678);
      rdChk(8'h40, 32'h0);
      // Width mode: 10-tick period, three-tick floor on pulses.
      wr(ADDR_CTRL, 32'h1);
      quiet();
      wr(ADDR_CTRL, 32'h9);
      lens(5, 5);
      yInc <= 10'd300;
      lens(3, 7);
      yInc <= 10'd250;
      quiet();
      yInc <= 10'd1000;
      yDec <= 10'd500;
      wr(ADDR_CTRL, 32'h11);
      lens(5, 5);
      wr(ADDR_HOLDV, 32'd700);
      holdActive <= 1'b1;
      wr(ADDR_CTRL, 32'h51);
      lens(7, 3);
      // Freeze keeps the held demand although the live part drops.
      yDec <= 10'd200;
      wr(ADDR_CTRL, 32'h31);
      lens(7, 3);
      holdActive <= 1'b0;
      // Frequency mode: pulse length from the rate, gap from the demand.
      yInc <= 10'd1000;
      wr(ADDR_CTRL, 32'hd);
      lens(5, 5);
      yInc <= 10'd500;
      lens(5, 15);
      yInc <= 10'd1000;
      wr(ADDR_FREQ, 32'd30);
      lens(10, 10);
      // Diagnostics: mapped set first, then each class in turn.
      wr(ADDR_CTRL, 32'h2);
      msgRelayMap <= 16'h0005;
      wr(ADDR_MAPPED, 32'hffffffff);
      rdChk(ADDR_MAPPED, 32'h00000005);
      relayIs(16'h0002, 1'b1);
      relayIs(16'h0004, 1'b0);
      wr(ADDR_CLASS, 32'h000000e4);
      for (int dm = 1; dm <= 4; dm++) begin
         wr(ADDR_CTRL, 32'h2 | (dm << 8));
         relayIs(16'h1 << (dm % 4), 1'b1);
         relayIs(16'h1 << (dm - 1), 1'b0);
      end
      // A failure-class message is standing, so the error bit is set and the relay off.
      rdChk(ADDR_STATUS, 32'h00000002);
      complete_run();
   end
endmodule

// ==== rpm_pkg.sv ====
// Notes on behaviour
// - Width mode keeps the period fixed at the cycle duration, varying on-share.
// - Frequency mode emits fixed-length pulses and varies only the gap.
// - At maximum pulse rate the gap equals the pulse length.
// - Actuator type picks increasing part, decreasing part or nothing; resets to nothing.
// - Increasing part raises the process value; decreasing part lowers it.
// - Cycle duration spans minimum on-time to 999.0 s, reset 10.0 s.
// - Cycle duration never falls below minimum on-time; each limits the other.
// - Minimum on-time spans 0.3 s to cycle duration, reset 0.3 s.
// - Width-mode pulses shorter than minimum on-time are dropped for that cycle; frequency-mode pulses are not checked against it.
// - Maximum pulse rate spans 1 to 180 per minute, reset 60.
// - Frequency-mode pulse length derives from the maximum pulse rate.
// - Diagnostic relay is fail-safe: energized without error, released on error.
// - The alarm relay resets to the fail-safe diagnostic function; a control write can change it.
// - Diagnostic source is one of four classes or the individually mapped set.
// - Mapped mode releases the relay only for messages mapped to it.
// - Class mode signals every message of the chosen class; classes are writable.
// - Diagnostic mode resets to mapped, or failure class on the alarm relay.
// - The mapped message list is read-only; writes to it are dropped.
// - Each relay picks width or frequency mode; width mode after reset.
// - A modulated relay alternates energized pulse and released interval phases.
// - Hold freezes, forces a fixed value, or is ignored; ignore after reset.
package rpm_pkg;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 10;
   localparam int TICK_MS         = 100;
   localparam int TICK_CYCLES     = TICK_MS * 1000000 / CLK_PERIOD_NS;
   localparam int MINUTE_MS       = 60000;
   localparam int CYCLE_MAX_MS    = 999000;
   localparam int CYCLE_RST_MS    = 10000;
   localparam int MINON_MIN_MS    = 300;
   localparam int CYCLE_MAX_TICKS = CYCLE_MAX_MS / TICK_MS;
   localparam int CYCLE_RST_TICKS = CYCLE_RST_MS / TICK_MS;
   localparam int MINON_MIN_TICKS = MINON_MIN_MS / TICK_MS;
   localparam int HALF_MIN_TICKS  = MINUTE_MS / TICK_MS / 2;
   localparam int FREQ_MIN        = 1;
   localparam int FREQ_MAX        = 180;
   localparam int FREQ_RST        = 60;
   localparam int Y_FULL          = 1000;
   localparam int MSG_N           = 16;
   localparam int TW              = 14;
   localparam int GW              = 20;
   // ---------------------------------------------------------------
   // Register map and fields
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_CYCLE  = 8'h04;
   localparam logic [7:0] ADDR_MINON  = 8'h08;
   localparam logic [7:0] ADDR_FREQ   = 8'h0c;
   localparam logic [7:0] ADDR_HOLDV  = 8'h10;
   localparam logic [7:0] ADDR_CLASS  = 8'h14;
   localparam logic [7:0] ADDR_MAPPED = 8'h18;
   localparam logic [7:0] ADDR_STATUS = 8'h1c;
   localparam int CTRL_FUNC_LSB  = 0;
   localparam int CTRL_MODE_BIT  = 2;
   localparam int CTRL_ACT_LSB   = 3;
   localparam int CTRL_HOLD_LSB  = 5;
   localparam int CTRL_DMODE_LSB = 8;
   localparam int STAT_Y_LSB     = 16;
   // ---------------------------------------------------------------
   // Enumerations
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {FUNC_OFF, FUNC_CTRL, FUNC_DIAG} rpm_func_e;
   typedef enum logic [1:0] {ACT_NONE, ACT_INC, ACT_DEC} rpm_act_e;
   typedef enum logic [1:0] {HOLD_IGNORE, HOLD_FREEZE, HOLD_FIXED} rpm_hold_e;
   typedef enum logic [2:0] {DM_MAPPED, DM_MAINT, DM_SPEC, DM_CHECK, DM_FAIL} rpm_dmode_e;
   typedef enum logic [1:0] {PH_IDLE, PH_PULSE, PH_GAP} rpm_phase_e;
   localparam logic [1:0] CTRL_RST_FUNC  = FUNC_OFF;
   localparam logic [2:0] CTRL_RST_DMODE = DM_MAPPED;
endpackage

// ==== rpm_tick.sv ====
`timescale 1ns/1ps
module rpm_tick #(
   parameter int DIV = 10
) (
   input  wire logic ref_clk,
   input  wire logic rst_n,
   output logic      tick
);
   localparam int CW = $clog2(DIV + 1);
   logic [CW-1:0] cnt_q;

   // ---------------------------------------------------------------
   // Divider
   // ---------------------------------------------------------------
   // Counts clock cycles and emits one enable pulse per tenth second.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cnt_q <= '0;
         tick  <= 1'b0;
      end else if (cnt_q == CW'(DIV - 1)) begin
         cnt_q <= '0;
         tick  <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 1'b1;
         tick  <= 1'b0;
      end
   end
endmodule
